// file: rtl/pdm_port_mux.v
// Port B/C/D register file with port D alternate-function overrides.
// Assumes an APB master on core_clk and pad cells that resolve the
// output enable, output value and pull-up enable per pin.
`timescale 1ns/1ps
`include "pdm_consts.vh"
module pdm_port_mux (
    input wire core_clk,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    input wire [7:0] pb_pin_in,
    output reg [7:0] pb_pin_out,
    output reg [7:0] pb_pin_oe,
    output reg [7:0] pb_pin_pullup,
    input wire [7:0] pc_pin_in,
    output reg [7:0] pc_pin_out,
    output reg [7:0] pc_pin_oe,
    output reg [7:0] pc_pin_pullup,
    input wire [7:0] pd_pin_in,
    output reg [7:0] pd_pin_out,
    output reg [7:0] pd_pin_oe,
    output reg [7:0] pd_pin_pullup,
    input wire serial_tx_data,
    input wire serial_clock_out,
    output wire serial_rx_data,
    output wire serial_clock_pin,
    output wire timer_zero_count_input,
    output wire timer_one_count_input,
    output wire ext_irq_zero_input,
    output wire ext_irq_one_input
);

// ----------------------------------------------------------------------------
// Declarations
// ----------------------------------------------------------------------------
reg [7:0] port_b_output_data;
reg [7:0] port_b_direction;
reg [7:0] port_c_output_data;
reg [7:0] port_c_direction;
reg [7:0] port_d_output_data;
reg [7:0] port_d_direction;
reg [`PDM_CTRL_W-1:0] ctrl;
wire [7:0] pb_level;
wire [7:0] pc_level;
wire [7:0] pd_level;
wire [7:0] pd_input_en;
wire serial_transmitter_enable;
wire serial_receiver_enable;
wire synchronous_mode_select;
wire global_pullup_disable;
wire irq0_enable;
wire irq1_enable;
wire wr_en;
wire rd_en;
wire [7:0] next_pd_out;
wire [7:0] next_pd_oe;
wire [7:0] next_pd_pullup;
wire [7:0] pd_plain_pullup;
reg [7:0] pullup_override_enable;
reg [7:0] pullup_override_value;
reg [7:0] direction_override_enable;
reg [7:0] direction_override_value;
reg [7:0] port_value_override_enable;
reg [7:0] port_value_override_value;
reg [7:0] input_enable_override_enable;
reg [7:0] input_enable_override_value;
genvar gp;

// Byte-lane merge used by every port register write; the control write checks pstrb[0] itself
function [7:0] lane0;
    input [7:0] old_val;
    input [31:0] wdata;
    input [3:0] strb;
    begin
        lane0 = strb[0] ? wdata[7:0] : old_val;
    end
endfunction

// Address hit test used by the write decode; the read decode uses a case on paddr
function hit;
    input [11:0] addr;
    input [11:0] off;
    begin
        hit = (addr == off);
    end
endfunction

// Plain-port pull-up: an input with its data bit set, unless disabled
function [7:0] plain_pullup;
    input [7:0] dir;
    input [7:0] data;
    input pull_off;
    begin
        plain_pullup = ~dir & data & {8{~pull_off}};
    end
endfunction

assign serial_transmitter_enable = ctrl[`PDM_CTRL_TX_ON];
assign serial_receiver_enable = ctrl[`PDM_CTRL_RX_ON];
assign synchronous_mode_select = ctrl[`PDM_CTRL_SYNC];
assign irq0_enable = ctrl[`PDM_CTRL_IRQ0];
assign irq1_enable = ctrl[`PDM_CTRL_IRQ1];
assign global_pullup_disable = ctrl[`PDM_CTRL_PUD];

// ----------------------------------------------------------------------------
// APB handshake: zero wait states, never an error
// ----------------------------------------------------------------------------
assign pready = 1'b1;
assign pslverr = 1'b0;
assign wr_en = psel & penable & pwrite;
assign rd_en = psel & ~pwrite;

// ----------------------------------------------------------------------------
// Pad input synchronisers
// ----------------------------------------------------------------------------
pdm_pin_sync #(.WIDTH(8)) u_sync_b (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_async(pb_pin_in),
    .pin_level(pb_level)
);

pdm_pin_sync #(.WIDTH(8)) u_sync_c (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_async(pc_pin_in),
    .pin_level(pc_level)
);

pdm_pin_sync #(.WIDTH(8)) u_sync_d (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_async(pd_pin_in),
    .pin_level(pd_level)
);

// ----------------------------------------------------------------------------
// Register writes
// ----------------------------------------------------------------------------
always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
        port_b_output_data <= `PDM_RST_BYTE; // [RL9]
        port_b_direction <= `PDM_RST_BYTE; // [RL9]
        port_c_output_data <= `PDM_RST_BYTE;
        port_c_direction <= `PDM_RST_BYTE;
        port_d_output_data <= `PDM_RST_BYTE;
        port_d_direction <= `PDM_RST_BYTE;
        ctrl <= {`PDM_CTRL_W{1'b0}};
    end else if (wr_en) begin
        if (hit(paddr, `PDM_OFF_PB_DATA)) begin
            port_b_output_data <= lane0(port_b_output_data, pwdata, pstrb); // [RL9]
        end
        if (hit(paddr, `PDM_OFF_PB_DIR)) begin
            port_b_direction <= lane0(port_b_direction, pwdata, pstrb); // [RL9]
        end
        // Bit 7 is masked to zero on every write, so writes to it vanish
        if (hit(paddr, `PDM_OFF_PC_DATA)) begin
            port_c_output_data <= lane0(port_c_output_data, pwdata, pstrb)
                & `PDM_PC_MASK; // [RL10]
        end
        if (hit(paddr, `PDM_OFF_PC_DIR)) begin
            port_c_direction <= lane0(port_c_direction, pwdata, pstrb)
                & `PDM_PC_MASK; // [RL10]
        end
        if (hit(paddr, `PDM_OFF_PD_DATA)) begin
            port_d_output_data <= lane0(port_d_output_data, pwdata, pstrb);
        end
        if (hit(paddr, `PDM_OFF_PD_DIR)) begin
            port_d_direction <= lane0(port_d_direction, pwdata, pstrb);
        end
        if (hit(paddr, `PDM_OFF_CTRL) && pstrb[0]) begin
            ctrl <= pwdata[`PDM_CTRL_W-1:0];
        end
    end
end

// ----------------------------------------------------------------------------
// Register reads, registered data
// ----------------------------------------------------------------------------
always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
        prdata <= 32'h00000000;
    end else if (rd_en & ~penable) begin
        prdata <= 32'h00000000;
        case (paddr)
            `PDM_OFF_PB_DATA: prdata[7:0] <= port_b_output_data;
            `PDM_OFF_PB_DIR: prdata[7:0] <= port_b_direction;
            `PDM_OFF_PB_PIN: prdata[7:0] <= pb_level; // [RL9] [RL11]
            `PDM_OFF_PC_DATA: prdata[7:0] <= port_c_output_data & `PDM_PC_MASK; // [RL10]
            `PDM_OFF_PC_DIR: prdata[7:0] <= port_c_direction & `PDM_PC_MASK; // [RL10]
            `PDM_OFF_PC_PIN: prdata[7:0] <= pc_level & `PDM_PC_MASK; // [RL11]
            `PDM_OFF_PD_DATA: prdata[7:0] <= port_d_output_data;
            `PDM_OFF_PD_DIR: prdata[7:0] <= port_d_direction;
            `PDM_OFF_PD_PIN: prdata[7:0] <= pd_level & pd_input_en; // [RL11]
            `PDM_OFF_CTRL: prdata[`PDM_CTRL_W-1:0] <= ctrl;
            default: prdata <= 32'h00000000;
        endcase
    end
end

// ----------------------------------------------------------------------------
// Port D override controls, one enable and one value per pin
// ----------------------------------------------------------------------------
// Everything off first, so unlisted pins keep the plain port behaviour
always @* begin
    pullup_override_enable = 8'h00;
    pullup_override_value = 8'h00;
    direction_override_enable = 8'h00;
    direction_override_value = 8'h00;
    port_value_override_enable = 8'h00;
    port_value_override_value = 8'h00;
    input_enable_override_enable = 8'h00;
    input_enable_override_value = 8'h00;
    // Receiver: input, pull-up still follows the data bit and the disable
    pullup_override_enable[`PDM_BIT_RX] = serial_receiver_enable; // [RL3]
    pullup_override_value[`PDM_BIT_RX] = port_d_output_data[`PDM_BIT_RX]
        & ~global_pullup_disable; // [RL3]
    direction_override_enable[`PDM_BIT_RX] = serial_receiver_enable; // [RL2] [RL4]
    // Transmitter: output, no pull-up, transmit data on the pad
    pullup_override_enable[`PDM_BIT_TX] = serial_transmitter_enable; // [RL4]
    direction_override_enable[`PDM_BIT_TX] = serial_transmitter_enable; // [RL1] [RL4]
    direction_override_value[`PDM_BIT_TX] = 1'b1; // [RL1] [RL4]
    port_value_override_enable[`PDM_BIT_TX] = serial_transmitter_enable; // [RL4]
    port_value_override_value[`PDM_BIT_TX] = serial_tx_data; // [RL4]
    // Synchronous mode: clock replaces the data bit, direction left to software
    port_value_override_enable[`PDM_BIT_SCLK] = synchronous_mode_select; // [RL5]
    port_value_override_value[`PDM_BIT_SCLK] = serial_clock_out; // [RL5]
    // Interrupt pins: input path forced on while the interrupt is enabled
    input_enable_override_enable[`PDM_BIT_IRQ0] = irq0_enable; // [RL6]
    input_enable_override_value[`PDM_BIT_IRQ0] = 1'b1; // [RL6]
    input_enable_override_enable[`PDM_BIT_IRQ1] = irq1_enable; // [RL6]
    input_enable_override_value[`PDM_BIT_IRQ1] = 1'b1; // [RL6]
    // Bit 5 and comparator bits 7..6 stay plain; software keeps 7..6 quiet
end

// ----------------------------------------------------------------------------
// Override mux per pin: an enabled override wins over the plain port
// ----------------------------------------------------------------------------
// Base input enable is high: no sleep logic here ever gates an input path
assign pd_plain_pullup = plain_pullup(port_d_direction, port_d_output_data,
    global_pullup_disable);
generate
    for (gp = 0; gp < 8; gp = gp + 1) begin : g_pd_pin
        assign next_pd_oe[gp] = direction_override_enable[gp]
            ? direction_override_value[gp] : port_d_direction[gp];
        assign next_pd_out[gp] = port_value_override_enable[gp]
            ? port_value_override_value[gp] : port_d_output_data[gp];
        assign next_pd_pullup[gp] = pullup_override_enable[gp]
            ? pullup_override_value[gp] : pd_plain_pullup[gp];
        assign pd_input_en[gp] = input_enable_override_enable[gp]
            ? input_enable_override_value[gp] : 1'b1; // [RL6]
    end
endgenerate

// ----------------------------------------------------------------------------
// Pad drive for all ports, registered to keep pad timing clean
// ----------------------------------------------------------------------------
// One cycle of latency traded for glitch-free pad controls
always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
        pb_pin_out <= 8'h00;
        pb_pin_oe <= 8'h00;
        pb_pin_pullup <= 8'h00;
        pc_pin_out <= 8'h00;
        pc_pin_oe <= 8'h00;
        pc_pin_pullup <= 8'h00;
        pd_pin_out <= 8'h00;
        pd_pin_oe <= 8'h00;
        pd_pin_pullup <= 8'h00;
    end else begin
        pb_pin_out <= port_b_output_data;
        pb_pin_oe <= port_b_direction;
        pb_pin_pullup <= plain_pullup(port_b_direction, port_b_output_data,
            global_pullup_disable);
        pc_pin_out <= port_c_output_data;
        pc_pin_oe <= port_c_direction;
        pc_pin_pullup <= plain_pullup(port_c_direction, port_c_output_data,
            global_pullup_disable);
        pd_pin_out <= next_pd_out;
        pd_pin_oe <= next_pd_oe;
        pd_pin_pullup <= next_pd_pullup;
    end
end

// ----------------------------------------------------------------------------
// Peripheral input routing from synchronised levels
// ----------------------------------------------------------------------------
assign serial_rx_data = pd_level[`PDM_BIT_RX];
assign ext_irq_zero_input = pd_level[`PDM_BIT_IRQ0]; // [RL6]
assign ext_irq_one_input = pd_level[`PDM_BIT_IRQ1]; // [RL6]
assign serial_clock_pin = pd_level[`PDM_BIT_SCLK]; // [RL5]
assign timer_zero_count_input = pd_level[`PDM_BIT_SCLK]; // [RL5]
assign timer_one_count_input = pd_level[`PDM_BIT_TMR1]; // [RL7]

endmodule // pdm_port_mux

// file: rtl/pdm_consts.vh
// Constants for the port D override block and its port B/C/D register file.
// Assumes an APB master with 32-bit data; included by bare name.
//
// What this block does
// [RL1] Transmitter enable forces port D bit 1 to output whatever its direction bit says.
// [RL2] Receiver enable forces port D bit 0 to input whatever its direction bit says.
// [RL3] With the receiver forcing bit 0 to input, its pull-up follows data bit 0 and pull-up disable.
// [RL4] Transmitter enable turns bit 1 pull-up off, drives it out and sends transmit data.
// [RL5] Synchronous mode puts the serial clock on bit 4, whose input feeds serial clock and timer 0.
// [RL6] An enabled external interrupt 1 or 0 forces the input path of bit 3 or 2 on.
// [RL7] Bit 5 input feeds the timer 1 count source with no override on that pin.
// [RL8] Software should make bits 7 and 6 inputs without pull-ups when the comparator uses them.
// [RL9] Port B has cleared read-write data and direction registers and a read-only pin level.
// [RL10] Port C data and direction keep bits 6 to 0 only; bit 7 reads 0 and ignores writes.
// [RL11] A pin-level read gives the synchronised level of each bit with its input enabled.
`ifndef PDM_CONSTS_VH
`define PDM_CONSTS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define PDM_OFF_PB_DATA 12'h000
`define PDM_OFF_PB_DIR 12'h004
`define PDM_OFF_PB_PIN 12'h008
`define PDM_OFF_PC_DATA 12'h00C
`define PDM_OFF_PC_DIR 12'h010
`define PDM_OFF_PC_PIN 12'h014
`define PDM_OFF_PD_DATA 12'h018
`define PDM_OFF_PD_DIR 12'h01C
`define PDM_OFF_PD_PIN 12'h020
`define PDM_OFF_CTRL 12'h024

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define PDM_PC_MASK 8'h7F
`define PDM_RST_BYTE 8'h00
`define PDM_CTRL_TX_ON 0
`define PDM_CTRL_RX_ON 1
`define PDM_CTRL_SYNC 2
`define PDM_CTRL_IRQ0 3
`define PDM_CTRL_IRQ1 4
`define PDM_CTRL_PUD 5
`define PDM_CTRL_W 6
`define PDM_BIT_RX 0
`define PDM_BIT_TX 1
`define PDM_BIT_IRQ0 2
`define PDM_BIT_IRQ1 3
`define PDM_BIT_SCLK 4
`define PDM_BIT_TMR1 5

`endif

// file: rtl/pdm_pin_sync.v
// Three-stage synchroniser bank for pad input levels.
// Assumes pads are asynchronous to core_clk.
`timescale 1ns/1ps
module pdm_pin_sync #(
    parameter WIDTH = 8
) (
    input wire core_clk,
    input wire sys_rst,
    input wire [WIDTH-1:0] pin_async,
    output reg [WIDTH-1:0] pin_level
);

reg [WIDTH-1:0] stage_a;
reg [WIDTH-1:0] stage_b;
reg [WIDTH-1:0] stage_c;
genvar gi;

// ----------------------------------------------------------------------------
// Per-bit chain; level moves only when stages two and three agree
// ----------------------------------------------------------------------------
generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
        always @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst) begin
                stage_a[gi] <= 1'b0;
                stage_b[gi] <= 1'b0;
                stage_c[gi] <= 1'b0;
                pin_level[gi] <= 1'b0;
            end else begin
                stage_a[gi] <= pin_async[gi];
                stage_b[gi] <= stage_a[gi];
                stage_c[gi] <= stage_b[gi];
                // Agreement filters a one-cycle disagreement
                if (stage_b[gi] == stage_c[gi]) begin
                    pin_level[gi] <= stage_c[gi];
                end
            end
        end
    end
endgenerate

endmodule // pdm_pin_sync

// file: test/pdm_port_mux_assertions.sv
// Checker for the port D override block: pad overrides and register reads.
// Assumes it sees only top ports; mirrors control and port registers from APB writes.
`timescale 1ns/1ps
`include "pdm_consts.vh"
module pdm_port_mux_assertions (
    input wire core_clk,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire [31:0] prdata,
    input wire [7:0] pd_pin_out,
    input wire [7:0] pd_pin_oe,
    input wire [7:0] pd_pin_pullup,
    input wire [7:0] pd_pin_in,
    input wire serial_tx_data,
    input wire serial_clock_out,
    input wire serial_clock_pin,
    input wire timer_zero_count_input
);
    reg [5:0] ctl;
    reg [7:0] pdd;
    reg [7:0] pdr;
    reg [7:0] pbd;
    wire wr_hit = psel & penable & pwrite & pstrb[0];
    wire rd_acc = psel & penable & ~pwrite;
    // Mirror of the registers, landing on the same edge as the design's
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctl <= 6'h00;
            pdd <= 8'h00;
            pdr <= 8'h00;
            pbd <= 8'h00;
        end else if (wr_hit) begin
            if (paddr == `PDM_OFF_CTRL) ctl <= pwdata[5:0];
            if (paddr == `PDM_OFF_PD_DATA) pdd <= pwdata[7:0];
            if (paddr == `PDM_OFF_PD_DIR) pdr <= pwdata[7:0];
            if (paddr == `PDM_OFF_PB_DATA) pbd <= pwdata[7:0];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // ------------------------------------------------------------------
    // Pad overrides one edge behind the registers, then register reads
    // ------------------------------------------------------------------
    AST_TX_DIR:
        assert property ($past(ctl[0]) |-> pd_pin_oe[1]) else $error("tx pin not output");
    AST_RX_DIR:
        assert property ($past(ctl[1]) |-> !pd_pin_oe[0]) else $error("rx pin not input");
    AST_RX_PULL:
        assert property ($past(ctl[1]) |-> pd_pin_pullup[0] == $past(pdd[0] & ~ctl[5]))
            else $error("rx pull-up wrong");
    AST_TX_DRIVE:
        assert property ($past(ctl[0]) |-> !pd_pin_pullup[1] && pd_pin_out[1] == $past(serial_tx_data))
            else $error("tx drive wrong");
    AST_SYNC_CLK:
        assert property ($past(ctl[2]) |-> pd_pin_out[4] == $past(serial_clock_out))
            else $error("serial clock not on pin");
    AST_CLK_FANOUT:
        assert property (!$past(sys_rst, 4) && $past(pd_pin_in[4], 3) == $past(pd_pin_in[4], 4)
            |-> serial_clock_pin == $past(pd_pin_in[4], 4)
            && timer_zero_count_input == $past(pd_pin_in[4], 4))
            else $error("bit 4 level not fed to serial clock and timer 0");
    AST_PIN5_PLAIN:
        assert property (pd_pin_oe[5] == $past(pdr[5]) && pd_pin_out[5] == $past(pdd[5])
            && pd_pin_pullup[5] == $past(~pdr[5] & pdd[5] & ~ctl[5])) else $error("bit 5 overridden");
    AST_PB_READ:
        assert property (rd_acc && paddr == `PDM_OFF_PB_DATA |-> prdata == {24'h000000, pbd})
            else $error("port B data read wrong");
    AST_PC_TOP:
        assert property (rd_acc && (paddr == `PDM_OFF_PC_DATA || paddr == `PDM_OFF_PC_DIR)
            |-> prdata[31:7] == 25'h0000000) else $error("port C bit 7 not zero");
endmodule // pdm_port_mux_assertions
bind pdm_port_mux pdm_port_mux_assertions chk_u (.core_clk, .sys_rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pd_pin_out, .pd_pin_oe, .pd_pin_pullup, .pd_pin_in,
    .serial_tx_data,
    .serial_clock_out, .serial_clock_pin, .timer_zero_count_input);

// file: test/pdm_board.sv
// Board model for one 8-bit port: resolves each pin from device and board drivers.
// Assumes board drive comes from the bench; no contention modelled.
`timescale 1ns/1ps
module pdm_board (
    input wire core_clk,
    input wire [7:0] pad_out,
    input wire [7:0] pad_oe,
    input wire [7:0] pad_pullup,
    input wire [7:0] ext_en,
    input wire [7:0] ext_val,
    output wire [7:0] level
);
    logic [7:0] float_pat = 8'h55;
    // Floating pins wander so a stale level never passes for a driven one
    always @(posedge core_clk) float_pat <= ~float_pat;
    // Device first, then board, then pull-up
    assign level = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
        | (~pad_oe & ~ext_en & (pad_pullup | float_pat));
endmodule // pdm_board

// file: test/port_d_alternate_function_override_tb.sv
// Bench for the port D override block with its port B/C/D registers.
// Assumes the board models on each port and a checker bound to the top.
`timescale 1ns/1ps
`include "pdm_consts.vh"
module port_d_alternate_function_override_tb;
    logic core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'hF;
    logic serial_tx_data = 0, serial_clock_out = 0;
    logic [7:0] ext_en = 8'h00, ext_b = 8'h00, ext_d = 8'h00;
    wire pready, pslverr, rx_d, sck, t0, t1, irq0, irq1;
    wire [31:0] prdata;
    wire [7:0] b_in, b_out, b_oe, b_pu, c_in, c_out, c_oe, c_pu, d_in, d_out, d_oe, d_pu;
    int err_count = 0, cmp_count = 0;
    always #4 core_clk = ~core_clk;
    pdm_port_mux dut_u (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .pready, .prdata, .pslverr, .pb_pin_in(b_in), .pb_pin_out(b_out),
        .pb_pin_oe(b_oe), .pb_pin_pullup(b_pu), .pc_pin_in(c_in), .pc_pin_out(c_out),
        .pc_pin_oe(c_oe), .pc_pin_pullup(c_pu), .pd_pin_in(d_in), .pd_pin_out(d_out),
        .pd_pin_oe(d_oe), .pd_pin_pullup(d_pu), .serial_tx_data, .serial_clock_out,
        .serial_rx_data(rx_d), .serial_clock_pin(sck), .timer_zero_count_input(t0),
        .timer_one_count_input(t1), .ext_irq_zero_input(irq0), .ext_irq_one_input(irq1));
    pdm_board brd_b (.core_clk, .pad_out(b_out), .pad_oe(b_oe), .pad_pullup(b_pu),
        .ext_en(8'hFF), .ext_val(ext_b), .level(b_in));
    pdm_board brd_c (.core_clk, .pad_out(c_out), .pad_oe(c_oe), .pad_pullup(c_pu),
        .ext_en(8'hFF), .ext_val(8'hFF), .level(c_in));
    pdm_board brd_d (.core_clk, .pad_out(d_out), .pad_oe(d_oe), .pad_pullup(d_pu),
        .ext_en(ext_en), .ext_val(ext_d), .level(d_in));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask
    // One setup and access phase, held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
        output logic [31:0] q);
        @(posedge core_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge core_clk);
        penable <= 1;
        do @(posedge core_clk); while (pready !== 1'b1);
        q = prdata;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        apb(1, a, d, q);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(0, a, 8'h00, q);
        chk(q, exp);
    endtask
    // Edges pass, then sample off the edge
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs;
        rdc(`PDM_OFF_PB_DATA, 0);
        rdc(`PDM_OFF_PB_DIR, 0);
        wr(`PDM_OFF_PB_DATA, 8'hA5);
        wr(`PDM_OFF_PB_DIR, 8'h5A);
        rdc(`PDM_OFF_PB_DATA, 32'hA5);
        rdc(`PDM_OFF_PB_DIR, 32'h5A);
        // Lane 0 off: this write must not land
        pstrb <= 4'h0;
        wr(`PDM_OFF_PB_DATA, 8'h00);
        pstrb <= 4'hF;
        rdc(`PDM_OFF_PB_DATA, 32'hA5);
        wr(`PDM_OFF_PC_DATA, 8'hFF);
        wr(`PDM_OFF_PC_DIR, 8'hFF);
        rdc(`PDM_OFF_PC_DATA, 32'h7F);
        rdc(`PDM_OFF_PC_DIR, 32'h7F);
        wr(12'h0FC, 8'hFF);
        rdc(12'h0FC, 0);
    endtask
    // Mixed port and board drive; read-only write must not stick
    task automatic t_pins;
        ext_b <= 8'hC3;
        wr(`PDM_OFF_PB_PIN, 8'h00);
        wt(8);
        chk({pslverr, b_pu, c_pu}, {1'b0, 8'hA5, 8'h00});
        rdc(`PDM_OFF_PB_PIN, 32'h81);
        rdc(`PDM_OFF_PC_PIN, 32'h7F);
    endtask
    task automatic t_serial;
        wr(`PDM_OFF_PD_DIR, 8'h00); // Comparator bits 7, 6 stay inputs, no pull-up
        wr(`PDM_OFF_PD_DATA, 8'h01);
        wr(`PDM_OFF_CTRL, 8'h03);
        serial_tx_data <= 1;
        wt(2);
        chk({d_oe[1:0], d_pu[1:0], d_out[1]}, 5'b10011);
        @(posedge core_clk);
        serial_tx_data <= 0;
        wt(2);
        chk(d_out[1], 0);
        wr(`PDM_OFF_PD_DIR, 8'h01);
        wr(`PDM_OFF_CTRL, 8'h22);
        wt(2);
        chk({d_oe[1:0], d_pu[0]}, 3'b000);
        @(posedge core_clk);
        ext_en <= 8'h01;
        ext_d <= 8'h01;
        wt(6);
        chk(rx_d, 1);
    endtask
    task automatic t_clk_irq;
        wr(`PDM_OFF_PD_DIR, 8'h30);
        wr(`PDM_OFF_PD_DATA, 8'h20);
        wr(`PDM_OFF_CTRL, 8'h1C);
        serial_clock_out <= 1;
        wt(2);
        chk({d_out[5:4], d_oe[5]}, 3'b111);
        wr(`PDM_OFF_PD_DIR, 8'h00);
        ext_en <= 8'h3C;
        ext_d <= 8'h3C;
        wt(6);
        chk({sck, t0, t1, irq1, irq0}, 5'h1F);
        @(posedge core_clk);
        ext_en <= 8'hFF;
        ext_d <= 8'h08;
        wt(6);
        chk({sck, t0, t1, irq1, irq0}, 5'h02);
        rdc(`PDM_OFF_PD_PIN, 32'h08);
        rdc(`PDM_OFF_CTRL, 32'h1C);
    endtask
    task automatic conclude;
        $display("compares %0d errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Main sequence after ten reset cycles
    initial begin
        repeat (10) @(posedge core_clk);
        sys_rst <= 0;
        t_regs();
        t_pins();
        t_serial();
        t_clk_irq();
        conclude();
    end
    // Watchdog, far beyond the roughly 130 cycles the run needs
    initial begin
        #200000;
        err_count++;
        conclude();
    end
endmodule // port_d_alternate_function_override_tb
